//--- include/alu_flags_pkg.sv
// constants shared by the flag and data-addressing datapath
package alu_flags_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_WORK = 8'h04;
  localparam logic [7:0] OFS_BANK = 8'h08;
  localparam logic [7:0] OFS_PTR0 = 8'h0C;
  localparam logic [7:0] OFS_PTR1 = 8'h10;
  localparam logic [7:0] OFS_PTR2 = 8'h14;
  localparam logic [7:0] OFS_CONFIG = 8'h18;
  localparam logic [7:0] OFS_EXEC = 8'h1C;
  localparam logic [7:0] OFS_OPERAND = 8'h20;
  localparam logic [7:0] OFS_RESULT = 8'h24;
  localparam logic [7:0] OFS_ADDRESS = 8'h28;
  localparam logic [7:0] OFS_TARGET = 8'h2C;
  // flag bit positions
  localparam int FLG_CARRY = 0;
  localparam int FLG_NIBBLE = 1;
  localparam int FLG_ZERO = 2;
  localparam int FLG_WRAP = 3;
  localparam int FLG_NEG = 4;
  localparam int FLG_W = 5;
  localparam logic [FLG_W-1:0] FLAGS_RESET = 5'h00;
  // exec word field positions
  localparam int EX_FA_LSB = 0;
  localparam int EX_ACCESS = 8;
  localparam int EX_DEST = 9;
  localparam int EX_OP_LSB = 10;
  localparam int EX_MODE_LSB = 14;
  localparam int EX_PSEL_LSB = 17;
  localparam int EX_CFG_EXTENDED_ISA_ENABLE = 0;
  localparam int EX_FULL_LSB = 20;
  // address space
  localparam int ADDR_W = 12;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] INDEX_LIMIT = 8'h5F;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [ADDR_W-1:0] PTR_STEP = 12'h001;
  // default address of the flag register within data memory
  localparam logic [ADDR_W-1:0] FLAG_ADDR_DEF = 12'hFF0;
  // operation codes
  typedef enum logic [3:0] {
    OP_ADD_WORK_FILE = 4'h0, OP_ADD_LITERAL_WORK = 4'h1,
    OP_LITERAL_MINUS_WORK = 4'h2, OP_FILE_MINUS_WORK = 4'h3,
    OP_FILE_CLEAR = 4'h4, OP_ROTATE_RIGHT = 4'h5, OP_ROTATE_LEFT = 4'h6,
    OP_BIT_SET = 4'h7, OP_BIT_CLEAR = 4'h8, OP_NIBBLE_SWAP = 4'h9,
    OP_WORK_TO_FILE = 4'hA, OP_LITERAL_TO_WORK = 4'hB,
    OP_AND_WORK_FILE = 4'hC, OP_JUMP = 4'hD
  } op_e;
  // addressing modes
  typedef enum logic [2:0] {
    AM_DIRECT = 3'h0, AM_FULL = 3'h1, AM_POINTER = 3'h2, AM_POST_INC = 3'h3,
    AM_POST_DEC = 3'h4, AM_PRE_INC = 3'h5, AM_PLUS_WORK = 3'h6
  } mode_e;
endpackage

//--- logic/alu_flags_and_data_addressing.sv
// flag generation, operand addressing and write-back steering behind apb
//
// Functional notes
// RL1: flag destination with flag effects drops result
// RL2: clearing flag register sets only zero flag
// RL3: software alters flags via non-flag instructions
// RL4: flag bits seven to five read zero
// RL5: negative flag follows result top bit
// RL6: signed wrap flag marks sign-bit overflow
// RL7: zero flag set when result is zero
// RL8: nibble carry from low four bits
// RL9: carry from most significant bit
// RL10: subtract adds complement; carries are active-low borrows
// RL11: rotate loads carry with shifted-out bit
// RL12: jump carries twenty-bit program target literal
// RL13: file address is opcode low byte
// RL14: banked access joins bank and file address
// RL15: access-bank mode ignores bank register
// RL16: full twelve-bit address ignores bank register
// RL17: destination bit picks file or work
// RL18: pointers address memory and are registers
// RL19: pointer aliases increment, decrement or offset
// RL20: indexed literal offset only with extended isa
// RL21: pointers hold twelve-bit linear addresses
// RL22: post-increment uses then bumps pointer
// RL23: pointer steps carry fully, touch no flag
// RL24: flag destination without effects takes result
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
module alu_flags_and_data_addressing #(
  parameter logic [11:0] FLAG_ADDR = alu_flags_pkg::FLAG_ADDR_DEF
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // data memory write port
  output logic [11:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  // program flow and flag view
  output logic [19:0] prog_target,
  output logic prog_load,
  output logic [4:0] flags_out
);
  // architectural state
  logic [4:0] flags; // condition flags
  logic [7:0] work; // working register
  logic [3:0] bank; // bank_select_reg
  logic [11:0] ptr [3]; // pointer_register pairs
  logic extended_isa_enable; // extended_isa_enable
  logic [7:0] operand; // file value supplied by memory side
  logic [7:0] result; // last computed result
  logic [11:0] last_addr; // last resolved address
  logic last_to_file; // last write-back went to file
  // bus decode
  logic acc; // access phase sampled this edge
  logic wr; // write takes effect this edge
  logic do_exec; // execute word written
  logic [7:0] ofs; // byte offset
  logic mapped; // offset is a register
  // decoded execute word
  logic [7:0] fa; // file address or literal
  logic a_bit; // access selector
  logic d_bit; // destination selector
  alu_flags_pkg::op_e op;
  alu_flags_pkg::mode_e mode;
  logic [1:0] psel_idx; // pointer number
  logic [11:0] full_addr; // full address field
  logic [2:0] bit_no; // bit number for set and clear
  // datapath results
  logic [11:0] next_addr; // resolved data address
  logic [11:0] next_ptr; // pointer after the access
  logic ptr_step; // pointer changes
  logic [7:0] fval; // file operand value
  logic [7:0] opa; // adder operand a
  logic [7:0] opb; // adder operand b, complemented on subtract
  logic cin; // adder carry in
  logic [8:0] sum; // full sum
  logic [4:0] nib; // low nibble sum
  logic [7:0] next_result; // computed result
  logic [4:0] fx; // flags the op affects
  logic [4:0] fv; // values of affected flags
  logic next_to_file; // result goes to file
  logic next_to_work; // result goes to work
  logic hits_flags; // resolved address is the flag register
  logic [4:0] next_flags; // flag register after exec
  logic [31:0] rd; // read mux

  // bus strobes; zero-wait slave
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign ofs = paddr[7:0];
  assign do_exec = wr && (ofs == alu_flags_pkg::OFS_EXEC);

  // execute word fields
  assign fa = pwdata[alu_flags_pkg::EX_FA_LSB +: 8]; // see RL13
  assign a_bit = pwdata[alu_flags_pkg::EX_ACCESS];
  assign d_bit = pwdata[alu_flags_pkg::EX_DEST];
  assign op = alu_flags_pkg::op_e'(pwdata[alu_flags_pkg::EX_OP_LSB +: 4]);
  assign mode = alu_flags_pkg::mode_e'(pwdata[alu_flags_pkg::EX_MODE_LSB +: 3]);
  assign psel_idx = pwdata[alu_flags_pkg::EX_PSEL_LSB +: 2];
  assign full_addr = pwdata[alu_flags_pkg::EX_FULL_LSB +: 12];
  assign bit_no = pwdata[alu_flags_pkg::EX_FULL_LSB +: 3];

  // operand address resolution
  always_comb begin
    logic [11:0] base;
    base = (psel_idx == 2'd3) ? ptr[2] : ptr[psel_idx];
    next_addr = base;
    next_ptr = base;
    ptr_step = 1'b0;
    unique case (mode)
      alu_flags_pkg::AM_DIRECT: begin
        if (a_bit) begin
          // banked: bank register supplies upper bits
          next_addr = {bank, fa}; // see RL14
        end else if (extended_isa_enable && fa <= alu_flags_pkg::INDEX_LIMIT) begin
          // indexed literal offset from pointer two
          next_addr = ptr[2] + {4'h0, fa}; // see RL20
        end else if (fa < alu_flags_pkg::ACCESS_SPLIT) begin
          // access bank low part, bank ignored
          next_addr = {alu_flags_pkg::ACCESS_LOW_BANK, fa}; // see RL15
        end else begin
          // access bank high part, bank ignored
          next_addr = {alu_flags_pkg::ACCESS_HIGH_BANK, fa}; // see RL15
        end
      end
      alu_flags_pkg::AM_FULL: begin
        next_addr = full_addr; // see RL16
      end
      alu_flags_pkg::AM_POINTER: begin
        next_addr = base; // see RL18
      end
      alu_flags_pkg::AM_POST_INC: begin
        // use then bump, carry runs through whole pair
        next_ptr = base + alu_flags_pkg::PTR_STEP; // see RL22
        ptr_step = 1'b1;
      end
      alu_flags_pkg::AM_POST_DEC: begin
        next_ptr = base - alu_flags_pkg::PTR_STEP; // see RL19
        ptr_step = 1'b1;
      end
      alu_flags_pkg::AM_PRE_INC: begin
        next_ptr = base + alu_flags_pkg::PTR_STEP; // see RL19
        next_addr = next_ptr;
        ptr_step = 1'b1;
      end
      alu_flags_pkg::AM_PLUS_WORK: begin
        // signed work offset, neither pointer nor work changes
        next_addr = base + {{4{work[7]}}, work}; // see RL19
      end
      default: begin
        next_addr = base;
      end
    endcase
  end

  // file operand: the flag register is read from here
  assign hits_flags = (next_addr == FLAG_ADDR);
  assign fval = hits_flags ? {3'h0, flags} : operand;

  // alu core
  always_comb begin
    opa = fval;
    opb = work;
    cin = 1'b0;
    next_result = 8'h00;
    fx = 5'h00;
    fv = 5'h00;
    next_to_file = 1'b0;
    next_to_work = 1'b0;
    unique case (op)
      alu_flags_pkg::OP_ADD_WORK_FILE,
      alu_flags_pkg::OP_ADD_LITERAL_WORK,
      alu_flags_pkg::OP_LITERAL_MINUS_WORK,
      alu_flags_pkg::OP_FILE_MINUS_WORK: begin
        // subtract adds two's complement of work
        if (op == alu_flags_pkg::OP_ADD_LITERAL_WORK ||
            op == alu_flags_pkg::OP_LITERAL_MINUS_WORK) begin
          opa = fa;
        end
        if (op == alu_flags_pkg::OP_LITERAL_MINUS_WORK ||
            op == alu_flags_pkg::OP_FILE_MINUS_WORK) begin
          opb = ~work; // see RL10
          cin = 1'b1;
        end
        next_result = sum[7:0];
        fx = 5'h1F;
        fv[alu_flags_pkg::FLG_CARRY] = sum[8]; // see RL9
        fv[alu_flags_pkg::FLG_NIBBLE] = nib[4]; // see RL8
        fv[alu_flags_pkg::FLG_WRAP] = (opa[7] == opb[7]) && (sum[7] != opa[7]); // see RL6
        fv[alu_flags_pkg::FLG_ZERO] = (sum[7:0] == 8'h00); // see RL7
        fv[alu_flags_pkg::FLG_NEG] = sum[7]; // see RL5
        next_to_file = d_bit && (op != alu_flags_pkg::OP_ADD_LITERAL_WORK) &&
                       (op != alu_flags_pkg::OP_LITERAL_MINUS_WORK); // see RL17
        next_to_work = !next_to_file;
      end
      alu_flags_pkg::OP_FILE_CLEAR: begin
        // only the zero flag is affected, and it is set
        next_result = 8'h00;
        fx[alu_flags_pkg::FLG_ZERO] = 1'b1; // see RL2
        fv[alu_flags_pkg::FLG_ZERO] = 1'b1;
        next_to_file = 1'b1;
      end
      alu_flags_pkg::OP_ROTATE_RIGHT, alu_flags_pkg::OP_ROTATE_LEFT: begin
        // rotate through carry
        if (op == alu_flags_pkg::OP_ROTATE_RIGHT) begin
          next_result = {flags[alu_flags_pkg::FLG_CARRY], fval[7:1]};
          fv[alu_flags_pkg::FLG_CARRY] = fval[0]; // see RL11
        end else begin
          next_result = {fval[6:0], flags[alu_flags_pkg::FLG_CARRY]};
          fv[alu_flags_pkg::FLG_CARRY] = fval[7]; // see RL11
        end
        fx[alu_flags_pkg::FLG_CARRY] = 1'b1;
        fx[alu_flags_pkg::FLG_ZERO] = 1'b1;
        fx[alu_flags_pkg::FLG_NEG] = 1'b1;
        fv[alu_flags_pkg::FLG_ZERO] = (next_result == 8'h00); // see RL7
        fv[alu_flags_pkg::FLG_NEG] = next_result[7]; // see RL5
        next_to_file = d_bit; // see RL17
        next_to_work = !d_bit;
      end
      alu_flags_pkg::OP_AND_WORK_FILE: begin
        // logic op: zero and negative only
        next_result = fval & work;
        fx[alu_flags_pkg::FLG_ZERO] = 1'b1;
        fx[alu_flags_pkg::FLG_NEG] = 1'b1;
        fv[alu_flags_pkg::FLG_ZERO] = (next_result == 8'h00); // see RL7
        fv[alu_flags_pkg::FLG_NEG] = next_result[7]; // see RL5
        next_to_file = d_bit; // see RL17
        next_to_work = !d_bit;
      end
      alu_flags_pkg::OP_BIT_SET: begin
        // no flag effects
        next_result = fval | (8'h01 << bit_no);
        next_to_file = 1'b1;
      end
      alu_flags_pkg::OP_BIT_CLEAR: begin
        next_result = fval & ~(8'h01 << bit_no);
        next_to_file = 1'b1;
      end
      alu_flags_pkg::OP_NIBBLE_SWAP: begin
        next_result = {fval[3:0], fval[7:4]};
        next_to_file = d_bit; // see RL17
        next_to_work = !d_bit;
      end
      alu_flags_pkg::OP_WORK_TO_FILE: begin
        next_result = work;
        next_to_file = 1'b1;
      end
      alu_flags_pkg::OP_LITERAL_TO_WORK: begin
        next_result = fa;
        next_to_work = 1'b1;
      end
      alu_flags_pkg::OP_JUMP: begin
        // program target only, no data effect
        next_result = 8'h00;
      end
      default: begin
        // unused codes do nothing
        next_result = 8'h00;
      end
    endcase
  end

  // shared adder with nibble tap
  assign sum = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
  assign nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};

  // flag register after an executed word
  always_comb begin
    next_flags = (flags & ~fx) | (fv & fx);
    if (next_to_file && hits_flags) begin
      if (fx != 5'h00) begin
        // result discarded, flags follow effects only
        next_flags = (flags & ~fx) | (fv & fx); // see RL1
      end else begin
        // plain write lands in implemented bits
        next_flags = next_result[4:0]; // see RL24
      end
    end
  end

  // apb answer timing: ready in every access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // offset decode
  always_comb begin
    unique case (ofs)
      alu_flags_pkg::OFS_FLAGS, alu_flags_pkg::OFS_WORK,
      alu_flags_pkg::OFS_BANK, alu_flags_pkg::OFS_PTR0,
      alu_flags_pkg::OFS_PTR1, alu_flags_pkg::OFS_PTR2,
      alu_flags_pkg::OFS_CONFIG, alu_flags_pkg::OFS_EXEC,
      alu_flags_pkg::OFS_OPERAND, alu_flags_pkg::OFS_RESULT,
      alu_flags_pkg::OFS_ADDRESS, alu_flags_pkg::OFS_TARGET: mapped = (paddr[31:8] == 24'h0);
      default: mapped = 1'b0;
    endcase
  end

  // read mux
  always_comb begin
    rd = 32'h0000_0000;
    unique case (ofs)
      alu_flags_pkg::OFS_FLAGS: rd = {27'h0, flags}; // see RL4
      alu_flags_pkg::OFS_WORK: rd = {24'h0, work};
      alu_flags_pkg::OFS_BANK: rd = {28'h0, bank};
      alu_flags_pkg::OFS_PTR0: rd = {20'h0, ptr[0]}; // see RL21
      alu_flags_pkg::OFS_PTR1: rd = {20'h0, ptr[1]};
      alu_flags_pkg::OFS_PTR2: rd = {20'h0, ptr[2]};
      alu_flags_pkg::OFS_CONFIG: rd = {31'h0, extended_isa_enable};
      alu_flags_pkg::OFS_OPERAND: rd = {24'h0, operand};
      alu_flags_pkg::OFS_RESULT: rd = {24'h0, result};
      alu_flags_pkg::OFS_ADDRESS: rd = {19'h0, last_to_file, last_addr};
      alu_flags_pkg::OFS_TARGET: rd = {12'h0, prog_target};
      default: rd = 32'h0000_0000;
    endcase
    if (!mapped) begin
      rd = 32'h0000_0000;
    end
  end

  // read data and error, captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : rd;
      pslverr <= !mapped;
    end
  end

  // flag register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= alu_flags_pkg::FLAGS_RESET;
    end else if (do_exec) begin
      flags <= next_flags;
    end else if (wr && ofs == alu_flags_pkg::OFS_FLAGS) begin
      flags <= pwdata[4:0];
    end
  end

  // work register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      work <= 8'h00;
    end else if (do_exec && next_to_work) begin
      work <= next_result; // see RL17
    end else if (wr && ofs == alu_flags_pkg::OFS_WORK) begin
      work <= pwdata[7:0];
    end
  end

  // bank, config and operand registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank <= 4'h0;
      extended_isa_enable <= 1'b0;
      operand <= 8'h00;
    end else if (wr) begin
      if (ofs == alu_flags_pkg::OFS_BANK) begin
        bank <= pwdata[3:0];
      end
      if (ofs == alu_flags_pkg::OFS_CONFIG) begin
        extended_isa_enable <= pwdata[alu_flags_pkg::EX_CFG_EXTENDED_ISA_ENABLE];
      end
      if (ofs == alu_flags_pkg::OFS_OPERAND) begin
        operand <= pwdata[7:0];
      end
    end
  end

  // pointer pairs: software writable, stepped by aliases without flags
  for (genvar i = 0; i < 3; i++) begin : g_ptr
    localparam logic [7:0] PTR_OFS = alu_flags_pkg::OFS_PTR0 + 8'(4 * i);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ptr[i] <= 12'h000;
      end else if (wr && ofs == PTR_OFS) begin
        ptr[i] <= pwdata[11:0]; // see RL18
      end else if (do_exec && ptr_step && (psel_idx == 2'(i) ||
                   (i == 2 && psel_idx == 2'd3))) begin
        ptr[i] <= next_ptr; // see RL23
      end
    end
  end

  // result trace and memory write port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= 8'h00;
      last_addr <= 12'h000;
      last_to_file <= 1'b0;
      mem_addr <= 12'h000;
      mem_wdata <= 8'h00;
      mem_we <= 1'b0;
    end else begin
      mem_we <= 1'b0;
      if (do_exec) begin
        result <= next_result;
        last_addr <= next_addr;
        last_to_file <= next_to_file;
        mem_addr <= next_addr;
        mem_wdata <= next_result;
        // flag register lives here, not in memory
        mem_we <= next_to_file && !hits_flags; // see RL17
      end
    end
  end

  // program target for jump
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_target <= 20'h00000;
      prog_load <= 1'b0;
    end else begin
      prog_load <= 1'b0;
      if (do_exec && op == alu_flags_pkg::OP_JUMP) begin
        prog_target <= {full_addr, fa}; // see RL12
        prog_load <= 1'b1;
      end
    end
  end

  // flag view follows the register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_out <= alu_flags_pkg::FLAGS_RESET;
    end else begin
      flags_out <= flags;
    end
  end
endmodule

//--- tb/alu_flags_and_data_addressing_asserts.sv
// port-level checker for the flag and addressing datapath
`timescale 1ns/1ps
module alu_flags_checker #(
  parameter logic [11:0] FLAG_ADDR = alu_flags_pkg::FLAG_ADDR_DEF
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // memory and program flow
  input wire logic [11:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  input wire logic [19:0] prog_target,
  input wire logic prog_load,
  input wire logic [4:0] flags_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // setup cycle and completed writes
  wire setup = psel && !penable;
  wire done_wr = psel && penable && pready && pwrite;
  wire ex_wr = done_wr && paddr == {24'h0, alu_flags_pkg::OFS_EXEC};
  wire flag_wr = done_wr && paddr == {24'h0, alu_flags_pkg::OFS_FLAGS};

  ready_after_setup_a: assert property (setup |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_cause_a: assert property (pready |-> $past(setup))
    else $error("ready without setup");
  unmapped_err_a: assert property (setup && paddr[7:0] > 8'h2C |=> pslverr && prdata == 32'h0)
    else $error("unmapped offset not refused");
  mapped_ok_a: assert property (setup && paddr <= 32'h2C && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped offset refused");
  flag_bits_a: assert property (pready && !pwrite && paddr == 32'h0 |-> prdata[31:5] == 27'h0)
    else $error("flag upper bits not zero");
  write_pulse_a: assert property (mem_we |=> !mem_we)
    else $error("write strobe too long");
  write_cause_a: assert property (mem_we |-> $past(ex_wr))
    else $error("write strobe without exec");
  flag_dest_a: assert property (mem_we |-> mem_addr != FLAG_ADDR)
    else $error("flag register written as file");
  jump_target_a: assert property (ex_wr && pwdata[13:10] == 4'hD |=>
    prog_load && prog_target == {$past(pwdata[31:20]), $past(pwdata[7:0])})
    else $error("jump target wrong");
  flags_view_a: assert property (flag_wr |=> ##1 flags_out == $past(pwdata[4:0], 2))
    else $error("flag view wrong");
endmodule

bind alu_flags_and_data_addressing alu_flags_checker #(.FLAG_ADDR(FLAG_ADDR)) alu_flags_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
  .prog_target(prog_target), .prog_load(prog_load), .flags_out(flags_out)
);

//--- tb/data_memory_model.sv
// data memory stand-in that records file write-backs
`timescale 1ns/1ps
module data_memory_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write port from the datapath
  input wire logic [11:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  // record of the last write
  output int writes,
  output logic [11:0] last_addr,
  output logic [7:0] last_data
);
  // capture each strobed write and count it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      writes <= 0;
      last_addr <= 12'h000;
      last_data <= 8'h00;
    end else if (mem_we) begin
      writes <= writes + 1;
      last_addr <= mem_addr;
      last_data <= mem_wdata;
    end
  end
endmodule

//--- tb/test_alu_flags_and_data_addressing.sv
// self-checking bench for the flag and addressing datapath
`timescale 1ns/1ps
module test_alu_flags_and_data_addressing;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
  logic pready, pslverr, mem_we, prog_load, err;
  logic [11:0] mem_addr, last_addr;
  logic [7:0] mem_wdata, last_data;
  logic [19:0] prog_target;
  logic [4:0] flags_out;
  int writes, n0, fail_count = 0, num_checks = 0;
  // 200 MHz core clock
  always #2.5 pclk = ~pclk;
  alu_flags_and_data_addressing alu_flags_and_data_addressing_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .prog_target(prog_target), .prog_load(prog_load), .flags_out(flags_out));
  data_memory_model data_memory_model_inst (
    .pclk(pclk), .presetn(presetn), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .writes(writes), .last_addr(last_addr), .last_data(last_data));
  // compare and count
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one apb transfer, waiting for ready without a bound and checking it came after one cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("ready wait", 1, n);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input string name, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, q);
  endtask
  // short register and mode names
  localparam logic [7:0] FL = alu_flags_pkg::OFS_FLAGS, WK = alu_flags_pkg::OFS_WORK;
  localparam logic [7:0] OPD = alu_flags_pkg::OFS_OPERAND, P0 = alu_flags_pkg::OFS_PTR0;
  localparam logic [2:0] DIR = alu_flags_pkg::AM_DIRECT;
  // exec word fields, high to low
  task automatic ex(input logic [3:0] op, input logic [2:0] md, input logic a,
    input logic d, input logic [7:0] fa, input logic [11:0] hi);
    apb(1'b1, alu_flags_pkg::OFS_EXEC, {hi, 3'b000, md, op, d, a, fa});
  endtask
  // unimplemented flag bits, pointer width, unmapped offset
  task automatic t_regs;
    wr(FL, 32'hFF);
    rd(FL, "flags", 32'h1F);
    wr(P0, 32'hF0FF);
    rd(P0, "ptr0", 32'h0FF);
    apb(1'b0, 8'h30, 32'hFFFF_FFFF);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, q);
  endtask
  // signed wrap on add, borrow polarity on subtract
  task automatic t_arith;
    wr(WK, 32'h7F);
    wr(OPD, 32'h01);
    wr(FL, 32'h00);
    ex(alu_flags_pkg::OP_ADD_WORK_FILE, DIR, 0, 0, 8'h10, 12'h0);
    rd(WK, "sum", 32'h80);
    rd(FL, "add flags", 32'h1A);
    chk("no file write", 0, writes);
    wr(OPD, 32'h05);
    wr(WK, 32'h05);
    ex(alu_flags_pkg::OP_FILE_MINUS_WORK, DIR, 0, 1, 8'h20, 12'h0);
    rd(FL, "sub flags", 32'h07);
    chk("file write", 1, writes);
    chk("file addr", 32'h020, {20'h0, last_addr});
    chk("file data", 0, {24'h0, last_data});
    ex(alu_flags_pkg::OP_LITERAL_MINUS_WORK, DIR, 0, 0, 8'h03, 12'h0);
    rd(WK, "difference", 32'hFE);
    rd(FL, "borrow flags", 32'h10);
  endtask
  // rotates through carry both ways
  task automatic t_rot;
    wr(FL, 32'h00);
    wr(OPD, 32'h81);
    ex(alu_flags_pkg::OP_ROTATE_LEFT, DIR, 0, 0, 8'h10, 12'h0);
    rd(WK, "rotl", 32'h02);
    rd(FL, "rotl flags", 32'h01);
    wr(OPD, 32'h02);
    ex(alu_flags_pkg::OP_ROTATE_RIGHT, DIR, 0, 0, 8'h10, 12'h0);
    rd(WK, "rotr", 32'h81);
    rd(FL, "rotr flags", 32'h10);
  endtask
  // flag register as destination
  task automatic t_flagdst;
    n0 = writes;
    wr(FL, 32'h10);
    wr(WK, 32'hF0);
    ex(alu_flags_pkg::OP_ADD_WORK_FILE, DIR, 0, 1, 8'hF0, 12'h0);
    rd(FL, "dest add", 32'h05);
    wr(FL, 32'h1B);
    ex(alu_flags_pkg::OP_FILE_CLEAR, DIR, 0, 1, 8'hF0, 12'h0);
    rd(FL, "dest clear", 32'h1F);
    wr(FL, 32'h00);
    ex(alu_flags_pkg::OP_BIT_SET, DIR, 0, 1, 8'hF0, 12'h3);
    rd(FL, "dest bit set", 32'h08);
    chk("flag writes", n0, writes);
  endtask
  // pointer modes, carry across the pair, flags untouched
  task automatic t_ptr;
    logic [2:0] md [5];
    logic [23:0] ex_ap [5];
    md = '{alu_flags_pkg::AM_POST_INC, alu_flags_pkg::AM_POST_DEC, alu_flags_pkg::AM_PRE_INC,
      alu_flags_pkg::AM_PLUS_WORK, alu_flags_pkg::AM_POINTER};
    ex_ap = '{24'h0FF100, 24'h1000FF, 24'h100100, 24'h0FF100, 24'h100100};
    wr(P0, 32'h0FF);
    wr(WK, 32'hFF);
    wr(FL, 32'h15);
    for (int i = 0; i < 5; i++) begin
      ex(alu_flags_pkg::OP_BIT_SET, md[i], 0, 1, 8'h00, 12'h0);
      apb(1'b0, alu_flags_pkg::OFS_ADDRESS, 32'h0);
      chk("ptr addr", {20'h0, ex_ap[i][23:12]}, {20'h0, q[11:0]});
      rd(P0, "ptr value", {20'h0, ex_ap[i][11:0]});
    end
    rd(FL, "ptr flags", 32'h15);
  endtask
  // jump literal target
  task automatic t_jump;
    ex(alu_flags_pkg::OP_JUMP, DIR, 0, 0, 8'h5D, 12'hABC);
    rd(alu_flags_pkg::OFS_TARGET, "target", 32'hABC5D);
  endtask
  // entry: config, mode, access, file address, expected address
  task automatic t_addr;
    logic [31:0] e [7];
    e = '{32'h0014_5345, 32'h0004_5045, 32'h0008_0F80, 32'h0111_2ABC,
      32'h1001_0210, 32'h1006_0F60, 32'h1011_0310};
    wr(alu_flags_pkg::OFS_BANK, 32'h3);
    wr(alu_flags_pkg::OFS_PTR2, 32'h200);
    for (int i = 0; i < 7; i++) begin
      wr(alu_flags_pkg::OFS_CONFIG, {31'h0, e[i][28]});
      ex(alu_flags_pkg::OP_BIT_CLEAR, e[i][26:24], e[i][20], 1, e[i][19:12], e[i][11:0]);
      apb(1'b0, alu_flags_pkg::OFS_ADDRESS, 32'h0);
      chk("address", {20'h0, e[i][11:0]}, {20'h0, q[11:0]});
      chk("mem addr", {20'h0, e[i][11:0]}, {20'h0, last_addr});
    end
    wr(alu_flags_pkg::OFS_CONFIG, 32'h0);
  endtask
  // verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_arith();
    t_rot();
    t_flagdst();
    t_ptr();
    t_jump();
    t_addr();
    final_report();
  end
  // some 82 transfers of 3 cycles; 20000 ns is ample
  initial begin
    #20000;
    fail_count++;
    final_report();
  end
endmodule
